// [design/mapa_arbiter.v]
// Function
// R1 - isr above peripherals above main: isr and peripheral requests stall main
// R2 - with isr above peripheral, isr request preempts an ongoing peripheral access
// R3 - peripheral above isr and main stalls cpu as long as it requests
// R4 - peripheral below main only gets cycles unused by every higher requester
// R5 - isr priority field bits 2..0 reads/writes, resets 0, upper bits zero
// R6 - main priority field bits 2..0 reads/writes, resets 1, upper bits zero
// R7 - dma one priority field bits 2..0 reads/writes, resets 2, upper bits zero
// R8 - numerically lower priority value wins the memory cycle
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "mapa_map.vh"
module mapa_arbiter (
	input wire clk,
	input wire nrst,
	input wire [`MAPA_ADDR_W-1:0] reg_addr,
	input wire [`MAPA_DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [`MAPA_DATA_W-1:0] reg_rdata,
	input wire req_isr,
	input wire req_main,
	input wire req_dma1,
	input wire req_dma2,
	output wire gnt_isr,
	output wire gnt_main,
	output wire gnt_dma1,
	output wire gnt_dma2,
	output wire cpu_stall
);
	wire [`MAPA_PRI_W-1:0] pri_isr;
	wire [`MAPA_PRI_W-1:0] pri_main;
	wire [`MAPA_PRI_W-1:0] pri_dma1;
	wire [`MAPA_PRI_W-1:0] pri_dma2;
	wire [`MAPA_PRI_W-1:0] wdat;
	assign wdat = reg_wdata[`MAPA_PRI_HI:0];

	mapa_pri_reg #(.RST_VAL(`MAPA_RST_ISR)) u_isr ( // R5
		.clk(clk),
		.nrst(nrst),
		.wr_en(reg_wr && (reg_addr == `MAPA_OFF_ISR)),
		.wr_data(wdat),
		.pri_r(pri_isr)
	);
	mapa_pri_reg #(.RST_VAL(`MAPA_RST_MAIN)) u_main ( // R6
		.clk(clk),
		.nrst(nrst),
		.wr_en(reg_wr && (reg_addr == `MAPA_OFF_MAIN)),
		.wr_data(wdat),
		.pri_r(pri_main)
	);
	mapa_pri_reg #(.RST_VAL(`MAPA_RST_DMA1)) u_dma1 ( // R7
		.clk(clk),
		.nrst(nrst),
		.wr_en(reg_wr && (reg_addr == `MAPA_OFF_DMA1)),
		.wr_data(wdat),
		.pri_r(pri_dma1)
	);
	mapa_pri_reg #(.RST_VAL(`MAPA_RST_DMA2)) u_dma2 (
		.clk(clk),
		.nrst(nrst),
		.wr_en(reg_wr && (reg_addr == `MAPA_OFF_DMA2)),
		.wr_data(wdat),
		.pri_r(pri_dma2)
	);

	// a requester beats another when its value is lower; ties go to the lower index
	// (isr, main, dma1, dma2) so exactly one winner exists in every cycle with a request, none when none asks
	reg [`MAPA_NREQ-1:0] gnt;
	reg [`MAPA_NREQ-1:0] req;
	reg [`MAPA_PRI_W-1:0] pri [0:`MAPA_NREQ-1];
	integer i;
	integer j;
	reg beaten;
	always @* begin
		req = {req_dma2, req_dma1, req_main, req_isr};
		pri[`MAPA_IDX_ISR] = pri_isr;
		pri[`MAPA_IDX_MAIN] = pri_main;
		pri[`MAPA_IDX_DMA1] = pri_dma1;
		pri[`MAPA_IDX_DMA2] = pri_dma2;
		gnt = {`MAPA_NREQ{1'b0}};
		beaten = 1'b0;
		for (i = 0; i < `MAPA_NREQ; i = i + 1) begin
			beaten = 1'b0;
			for (j = 0; j < `MAPA_NREQ; j = j + 1) begin
				if (req[j] && (j != i)) begin
					if ((pri[j] < pri[i]) || ((pri[j] == pri[i]) && (j < i))) begin // R8
						beaten = 1'b1;
					end
				end
			end
			// decided afresh each cycle: a higher request takes the same cycle in which it is raised
			gnt[i] = req[i] && !beaten; // R1 R2 R3 R4
		end
	end

	assign gnt_isr = gnt[`MAPA_IDX_ISR];
	assign gnt_main = gnt[`MAPA_IDX_MAIN];
	assign gnt_dma1 = gnt[`MAPA_IDX_DMA1];
	assign gnt_dma2 = gnt[`MAPA_IDX_DMA2];
	// main routine is stalled whenever it asks but another holds memory
	assign cpu_stall = req_main && !gnt_main; // R1 R3

	wire [`MAPA_UNUSED_W-1:0] zpad;
	assign zpad = {`MAPA_UNUSED_W{1'b0}};
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= `MAPA_ZERO_RD;
		end else if (reg_rd) begin
			case (reg_addr)
				`MAPA_OFF_ISR: reg_rdata <= {zpad, pri_isr}; // R5
				`MAPA_OFF_MAIN: reg_rdata <= {zpad, pri_main}; // R6
				`MAPA_OFF_DMA1: reg_rdata <= {zpad, pri_dma1}; // R7
				`MAPA_OFF_DMA2: reg_rdata <= {zpad, pri_dma2};
				`MAPA_OFF_GRANT: reg_rdata <= {{(`MAPA_DATA_W-`MAPA_NREQ){1'b0}}, gnt};
				default: reg_rdata <= `MAPA_ZERO_RD;
			endcase
		end else begin
			reg_rdata <= `MAPA_ZERO_RD;
		end
	end
endmodule

// [design/mapa_map.vh]
`ifndef MAPA_MAP_VH
`define MAPA_MAP_VH
// register indices on the plain register port
`define MAPA_ADDR_W 4
`define MAPA_OFF_ISR 4'h0
`define MAPA_OFF_MAIN 4'h1
`define MAPA_OFF_DMA1 4'h2
`define MAPA_OFF_DMA2 4'h3
`define MAPA_OFF_GRANT 4'h4
// field layout
`define MAPA_PRI_W 3
`define MAPA_PRI_HI 2
`define MAPA_DATA_W 8
`define MAPA_UNUSED_W 5
// reset values
`define MAPA_RST_ISR 3'h0
`define MAPA_RST_MAIN 3'h1
`define MAPA_RST_DMA1 3'h2
`define MAPA_RST_DMA2 3'h3
// requester indices inside the grant vector
`define MAPA_NREQ 4
`define MAPA_IDX_ISR 0
`define MAPA_IDX_MAIN 1
`define MAPA_IDX_DMA1 2
`define MAPA_IDX_DMA2 3
`define MAPA_ZERO_RD 8'h00
`endif

// [design/mapa_pri_reg.v]
`timescale 1ns/1ps
`include "mapa_map.vh"
// one 3-bit priority field with its own reset value
module mapa_pri_reg #(
	parameter [`MAPA_PRI_W-1:0] RST_VAL = 3'h0
) (
	input wire clk,
	input wire nrst,
	input wire wr_en,
	input wire [`MAPA_PRI_W-1:0] wr_data,
	output reg [`MAPA_PRI_W-1:0] pri_r
);
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pri_r <= RST_VAL;
		end else if (wr_en) begin
			pri_r <= wr_data;
		end
	end
endmodule

// [tb/mapa_arbiter_assertions.sv]
`timescale 1ns/1ps
module mapa_arbiter_chk(input wire clk, nrst, reg_rd, req_isr, req_main, req_dma1, req_dma2,
	gnt_isr, gnt_main, gnt_dma1, gnt_dma2, cpu_stall, input wire [3:0] reg_addr,
	input wire [7:0] reg_rdata);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	one_grant_a: assert property ($onehot0({gnt_isr, gnt_main, gnt_dma1, gnt_dma2}))
		else $error("grant");
	isr_gnt_a: assert property (gnt_isr |-> req_isr) else $error("isr");
	main_stall_a: assert property (cpu_stall == (req_main && !gnt_main)) else $error("st");
	dma_stall_a: assert property (req_main && gnt_dma1 |-> cpu_stall) else $error("dma");
	free_cycle_a: assert property (req_dma2 && !req_isr && !req_main && !req_dma1 |-> gnt_dma2)
		else $error("idle");
	isr_rd_a: assert property (reg_rd && reg_addr == 0 |=> !reg_rdata[7:3]) else $error("rd");
	main_rd_a: assert property (reg_rd && reg_addr == 1 |=> !reg_rdata[7:3]) else $error("rd");
	dma_rd_a: assert property (reg_rd && reg_addr == 2 |=> !reg_rdata[7:3]) else $error("rd");
endmodule
bind mapa_arbiter mapa_arbiter_chk u_mapa_arbiter_chk(.*);

// [tb/mapa_arbiter_tb.sv]
`timescale 1ns/1ps
module mapa_arbiter_tb;
	logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, req_isr, req_main, req_dma1, req_dma2;
	logic gnt_isr, gnt_main, gnt_dma1, gnt_dma2, cpu_stall;
	logic [3:0] reg_addr = 0, want = 0;
	logic [7:0] reg_wdata = 0, reg_rdata;
	int fails, compares;
	logic [7:0] rows [7] = '{8'h62, 8'h71, 8'h44, 8'hC4, 8'h88, 8'hE2, 8'h91};
	mapa_arbiter u_mapa_arbiter(.*);
	mapa_partner u_mapa_partner(.*, .req({req_dma2, req_dma1, req_main, req_isr}));
	task stop_test;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] got, exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %0t %h", $time, got);
		end
	endtask
	task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
		@(posedge clk) {reg_wr, reg_rd} <= 2'h0;
		#1 if (!w) chk(reg_rdata, d);
	endtask
	task go(input logic [3:0] w, g);
		@(posedge clk) want <= w;
		@(posedge clk) #1 chk({gnt_dma2, gnt_dma1, gnt_main, gnt_isr, cpu_stall}, {g, w[1] & !g[1]});
	endtask
	initial forever #25 clk = ~clk;
	initial begin
		#100000 fails++;
		stop_test;
	end
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1;
		foreach (rows[i]) go(rows[i][7:4], rows[i][3:0]);
		$display("table end");
		acc(0, 0, 8'h00);
		acc(0, 1, 8'h01);
		acc(0, 2, 8'h02);
		acc(0, 15, 8'h00);
		// ones in the upper bits must not stick
		acc(1, 2, 8'hF8);
		acc(1, 0, 8'hF9);
		acc(1, 1, 8'h02);
		acc(0, 2, 8'h00);
		acc(0, 0, 8'h01);
		acc(0, 1, 8'h02);
		go(7, 4);
		go(15, 4);
		acc(1, 2, 8'h03);
		go(5, 1);
		acc(0, 4, 8'h01);
		acc(1, 3, 8'h00);
		acc(0, 3, 8'h00);
		go(9, 8);
		acc(1, 1, 8'h07);
		go(6, 4);
		$display("priority end");
		@(posedge clk) nrst <= 0;
		repeat (2) @(posedge clk);
		nrst <= 1;
		acc(0, 1, 8'h01);
		acc(0, 2, 8'h02);
		acc(0, 3, 8'h03);
		$display("reset end");
		stop_test;
	end
endmodule

// [tb/mapa_partner.sv]
`timescale 1ns/1ps
// masters launch request levels just after the edge
module mapa_partner(input wire clk, input wire [3:0] want, output reg [3:0] req = 4'h0);
	always @(posedge clk) begin
		req <= want;
	end
endmodule
